// *** design/gcca_pkg.sv ***
// Shared constants and types of the gauge control and its host controller.
package gcca_pkg;
  // Device register addresses on the register port.
  localparam logic [3:0] A_STATUS = 4'h0;
  localparam logic [3:0] A_CTRL   = 4'h1;
  localparam logic [3:0] A_ACR_HI = 4'h2;
  localparam logic [3:0] A_ACR_LO = 4'h3;
  localparam logic [3:0] A_CHH_HI = 4'h4;
  localparam logic [3:0] A_CHH_LO = 4'h5;
  localparam logic [3:0] A_CHL_HI = 4'h6;
  localparam logic [3:0] A_CHL_LO = 4'h7;
  localparam logic [3:0] A_VOLT_HI = 4'h8;
  localparam logic [3:0] A_VOLT_LO = 4'h9;
  localparam logic [3:0] A_VTH_HI = 4'ha;
  localparam logic [3:0] A_VTH_LO = 4'hb;
  localparam logic [3:0] A_TEMP_HI = 4'hc;
  localparam logic [3:0] A_TEMP_LO = 4'hd;
  localparam logic [3:0] A_TTH_HI = 4'he;
  localparam logic [3:0] A_TTH_LO = 4'hf;
  // Control register fields and reset values.
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int PS_HI   = 5;
  localparam int PS_LO   = 3;
  localparam int PIN_AL  = 2;
  localparam int PIN_CC  = 1;
  localparam int SHDN    = 0;
  localparam logic [1:0] MODE_SLEEP = 2'h0;
  localparam logic [1:0] MODE_TEMP  = 2'h1;
  localparam logic [1:0] MODE_VOLT  = 2'h2;
  localparam logic [1:0] MODE_SCAN  = 2'h3;
  localparam logic [1:0] PIN_BOTH   = 2'h3;
  localparam logic [7:0] CTRL_RST   = 8'h3c;
  localparam logic [15:0] ACR_RST   = 16'h7fff;
  localparam logic [15:0] ACR_FULL  = 16'hffff;
  localparam logic [15:0] ACR_EMPTY = 16'h0000;
  localparam logic [15:0] THR_HI_RST = 16'hffff;
  localparam logic [15:0] THR_LO_RST = 16'h0000;
  localparam logic [11:0] SUB_STEPS = 12'h008;
  // Status flag positions.
  localparam int F_OVF  = 5;
  localparam int F_TEMP = 4;
  localparam int F_CHH  = 3;
  localparam int F_CHL  = 2;
  localparam int F_VOLT = 1;
  // Timing at the 250 MHz clock.
  localparam int CLK_MHZ       = 250;
  localparam int CONV_TIME_MS  = 10;
  localparam int SCAN_SLEEP_MS = 2000;
  localparam int CONV_CYC = CONV_TIME_MS * 1000 * CLK_MHZ;
  localparam int SCAN_CYC = SCAN_SLEEP_MS * 1000 * CLK_MHZ;
  // Host controller register byte offsets.
  localparam logic [3:0] H_CMD    = 4'h0;
  localparam logic [3:0] H_STAT   = 4'h4;
  localparam logic [3:0] H_RESULT = 4'h8;
  // Host command word fields.
  localparam int C_READ = 12;
  localparam int C_PAIR = 13;
  localparam int C_ARA  = 14;

  typedef enum logic [1:0] {
    SQ_SLEEP, SQ_CONV_V, SQ_CONV_T, SQ_SCAN_WAIT
  } gcca_seq_t;

  typedef enum logic [1:0] {
    HS_IDLE, HS_WAIT1, HS_WAIT2
  } gcca_hst_t;
endpackage : gcca_pkg

// *** design/gcca_if.sv ***
// Link between the gauge device and its host controller.
`timescale 1ns/100ps
`default_nettype none
interface gcca_if;
  logic       wr;        // Register write strobe.
  logic       rd;        // Register read strobe.
  logic [3:0] addr;      // Register address.
  logic [7:0] wdata;     // Write data.
  logic [7:0] rdata;     // Read data.
  logic       rvalid;    // Read data valid pulse.
  logic       ara;       // Alert response completed pulse.
  logic       pin_out;   // Device drive value of the dual pin.
  logic       pin_oe_n;  // Device drives the dual pin when low.
  logic       pin_ext;   // External level on the dual pin.
  logic       pin_lvl;   // Resolved dual pin level.

  // The pin level is the device drive when enabled, else the outside.
  assign pin_lvl = pin_oe_n ? pin_ext : pin_out;

  modport dev  (input wr, rd, addr, wdata, ara, pin_lvl,
                output rdata, rvalid, pin_out, pin_oe_n);
  modport host (output wr, rd, addr, wdata, ara,
                input rdata, rvalid, pin_lvl);
endinterface : gcca_if
`default_nettype wire

// *** design/gcca_device.sv ***
// Gauge control, conversion sequencer and charge accumulator.
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module gcca_device #(
  parameter int unsigned CONV_CYC = gcca_pkg::CONV_CYC,  // Conversion time.
  parameter int unsigned SCAN_CYC = gcca_pkg::SCAN_CYC,  // Scan sleep time.
  parameter logic        CHIP_ID  = 1'b0                 // Arbitrary value.
) (
  input  wire logic        hclk,        // Clock.
  input  wire logic        hresetn,     // Asynchronous reset, active low.
  gcca_if.dev              link,        // Link to the host.
  input  wire logic        chg_up,      // One sub-step of charge in.
  input  wire logic        chg_dn,      // One sub-step of charge out.
  input  wire logic [15:0] adc_volt,    // Voltage converter result.
  input  wire logic [15:0] adc_temp,    // Temperature converter result.
  output logic             analog_off,  // Analog section shut down.
  output logic             conv_volt,   // Voltage conversion running.
  output logic             conv_temp,   // Temperature conversion running.
  output logic [15:0]      acr_value    // Charge accumulator value.
);
  typedef struct packed {
    gcca_pkg::gcca_seq_t seq;
    logic [31:0] tmr;
    logic [7:0]  ctrl;
    logic [15:0] charge_accumulator;
    logic [11:0] resid;
    logic [15:0] chh;
    logic [15:0] chl;
    logic [15:0] volt;
    logic [15:0] temp;
    logic [7:0]  vth_hi;
    logic [7:0]  vth_lo;
    logic [7:0]  tth_hi;
    logic [7:0]  tth_lo;
    logic [5:0]  flags;
    logic        alert;
    logic [7:0]  lo_shadow;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        cc_s1;
    logic        cc_s2;
  } gcca_dev_st_t;

  gcca_dev_st_t q;
  gcca_dev_st_t n;
  logic [11:0]  lim;
  logic [5:0]   cond;
  logic [5:0]   set;
  logic         sat_ev;
  logic         end_v;
  logic         end_t;
  logic [1:0]   mode;

  // Byte threshold test on the upper result byte.
  function automatic logic over(input logic [15:0] res,
                                input logic [7:0] hi,
                                input logic [7:0] lo);
    over = (res[15:8] > hi) || (res[15:8] < lo);
  endfunction : over

  // Next-state logic of the whole device.
  always_comb begin
    n        = q;
    n.rvalid = 1'b0;
    n.cc_s1  = link.pin_lvl;
    n.cc_s2  = q.cc_s1;
    mode     = q.ctrl[gcca_pkg::MODE_HI:gcca_pkg::MODE_LO];
    sat_ev   = 1'b0;
    end_v    = 1'b0;
    end_t    = 1'b0;
    lim = gcca_pkg::SUB_STEPS << q.ctrl[gcca_pkg::PS_HI:gcca_pkg::PS_LO];
    // Sub-step integration; shutdown drops the residue and the input.
    if (q.ctrl[gcca_pkg::SHDN]) begin
      n.resid = '0;
    end else if (chg_up && !chg_dn) begin
      if (q.resid + 12'h001 >= lim) begin
        n.resid = '0;
        if (q.charge_accumulator == gcca_pkg::ACR_FULL) begin
          sat_ev = 1'b1;
        end else begin
          n.charge_accumulator = q.charge_accumulator + 16'h0001;
        end
      end else begin
        n.resid = q.resid + 12'h001;
      end
    end else if (chg_dn && !chg_up) begin
      if ($signed(q.resid) - 12'sd1 <= -$signed(lim)) begin
        n.resid = '0;
        if (q.charge_accumulator == gcca_pkg::ACR_EMPTY) begin
          sat_ev = 1'b1;
        end else begin
          n.charge_accumulator = q.charge_accumulator - 16'h0001;
        end
      end else begin
        n.resid = q.resid - 12'h001;
      end
    end
    // Conversion sequencer; its timer stands still in shutdown.
    case (q.seq)
      gcca_pkg::SQ_SLEEP: begin
        n.tmr = '0;
        if (!q.ctrl[gcca_pkg::SHDN]) begin
          if (mode == gcca_pkg::MODE_VOLT || mode == gcca_pkg::MODE_SCAN) begin
            n.seq = gcca_pkg::SQ_CONV_V;
          end else if (mode == gcca_pkg::MODE_TEMP) begin
            n.seq = gcca_pkg::SQ_CONV_T;
          end
        end
      end
      gcca_pkg::SQ_CONV_V: begin
        if (q.ctrl[gcca_pkg::SHDN]) begin
          n.tmr = q.tmr;
        end else if (q.tmr == CONV_CYC - 1) begin
          end_v  = 1'b1;
          n.volt = adc_volt;
          n.tmr  = '0;
          if (mode == gcca_pkg::MODE_SCAN) begin
            n.seq = gcca_pkg::SQ_CONV_T;
          end else begin
            n.seq = gcca_pkg::SQ_SLEEP;
            if (mode == gcca_pkg::MODE_VOLT) begin
              n.ctrl[gcca_pkg::MODE_HI:gcca_pkg::MODE_LO] =
                gcca_pkg::MODE_SLEEP;
            end
          end
        end else begin
          n.tmr = q.tmr + 32'h1;
        end
      end
      gcca_pkg::SQ_CONV_T: begin
        if (q.ctrl[gcca_pkg::SHDN]) begin
          n.tmr = q.tmr;
        end else if (q.tmr == CONV_CYC - 1) begin
          end_t  = 1'b1;
          n.temp = adc_temp;
          n.tmr  = '0;
          if (mode == gcca_pkg::MODE_SCAN) begin
            n.seq = gcca_pkg::SQ_SCAN_WAIT;
          end else begin
            n.seq = gcca_pkg::SQ_SLEEP;
            if (mode == gcca_pkg::MODE_TEMP) begin
              n.ctrl[gcca_pkg::MODE_HI:gcca_pkg::MODE_LO] =
                gcca_pkg::MODE_SLEEP;
            end
          end
        end else begin
          n.tmr = q.tmr + 32'h1;
        end
      end
      gcca_pkg::SQ_SCAN_WAIT: begin
        if (mode != gcca_pkg::MODE_SCAN) begin
          n.seq = gcca_pkg::SQ_SLEEP;
          n.tmr = '0;
        end else if (q.ctrl[gcca_pkg::SHDN]) begin
          n.tmr = q.tmr;
        end else if (q.tmr == SCAN_CYC - 1) begin
          n.seq = gcca_pkg::SQ_CONV_V;
          n.tmr = '0;
        end else begin
          n.tmr = q.tmr + 32'h1;
        end
      end
      default: begin
        n.seq = gcca_pkg::SQ_SLEEP;
      end
    endcase
    // Register writes from the host; a control write wins the mode clear.
    if (link.wr) begin
      case (link.addr)
        gcca_pkg::A_CTRL:   n.ctrl        = link.wdata;
        gcca_pkg::A_ACR_HI: n.charge_accumulator[15:8]   = link.wdata;
        gcca_pkg::A_ACR_LO: n.charge_accumulator[7:0]    = link.wdata;
        gcca_pkg::A_CHH_HI: n.chh[15:8]   = link.wdata;
        gcca_pkg::A_CHH_LO: n.chh[7:0]    = link.wdata;
        gcca_pkg::A_CHL_HI: n.chl[15:8]   = link.wdata;
        gcca_pkg::A_CHL_LO: n.chl[7:0]    = link.wdata;
        gcca_pkg::A_VTH_HI: n.vth_hi      = link.wdata;
        gcca_pkg::A_VTH_LO: n.vth_lo      = link.wdata;
        gcca_pkg::A_TTH_HI: n.tth_hi      = link.wdata;
        gcca_pkg::A_TTH_LO: n.tth_lo      = link.wdata;
        default:            n.ctrl        = n.ctrl;
      endcase
    end
    // A synchronised full input in charge-complete mode wins all else.
    if (q.ctrl[gcca_pkg::PIN_CC] && q.cc_s2) begin
      n.charge_accumulator = gcca_pkg::ACR_FULL;
    end
    // Flag causes and events; set wins over the read clear.
    cond = '0;
    cond[gcca_pkg::F_OVF]  = (q.charge_accumulator == gcca_pkg::ACR_FULL) ||
                             (q.charge_accumulator == gcca_pkg::ACR_EMPTY);
    cond[gcca_pkg::F_TEMP] = over(q.temp, q.tth_hi, q.tth_lo);
    cond[gcca_pkg::F_CHH]  = q.charge_accumulator > q.chh;
    cond[gcca_pkg::F_CHL]  = q.charge_accumulator < q.chl;
    cond[gcca_pkg::F_VOLT] = over(q.volt, q.vth_hi, q.vth_lo);
    set = '0;
    set[gcca_pkg::F_OVF]  = sat_ev;
    set[gcca_pkg::F_TEMP] = end_t && over(adc_temp, q.tth_hi, q.tth_lo);
    set[gcca_pkg::F_CHH]  = cond[gcca_pkg::F_CHH];
    set[gcca_pkg::F_CHL]  = cond[gcca_pkg::F_CHL];
    set[gcca_pkg::F_VOLT] = end_v && over(adc_volt, q.vth_hi, q.vth_lo);
    if (link.rd && link.addr == gcca_pkg::A_STATUS) begin
      n.flags = set | (q.flags & cond);
    end else begin
      n.flags = set | q.flags;
    end
    // Alert latches on a new flag; the response clears it, set wins.
    n.alert = (q.ctrl[gcca_pkg::PIN_AL] && (|(set & ~q.flags))) ||
              (q.alert && !link.ara);
    // Register reads answer one cycle later.
    if (link.rd) begin
      n.rvalid = 1'b1;
      case (link.addr)
        gcca_pkg::A_STATUS:  n.rdata = {CHIP_ID, 1'b0, q.flags};
        gcca_pkg::A_CTRL:    n.rdata = q.ctrl;
        gcca_pkg::A_ACR_HI:  n.rdata = q.charge_accumulator[15:8];
        gcca_pkg::A_ACR_LO:  n.rdata = q.lo_shadow;
        gcca_pkg::A_CHH_HI:  n.rdata = q.chh[15:8];
        gcca_pkg::A_CHH_LO:  n.rdata = q.chh[7:0];
        gcca_pkg::A_CHL_HI:  n.rdata = q.chl[15:8];
        gcca_pkg::A_CHL_LO:  n.rdata = q.chl[7:0];
        gcca_pkg::A_VOLT_HI: n.rdata = q.volt[15:8];
        gcca_pkg::A_VOLT_LO: n.rdata = q.volt[7:0];
        gcca_pkg::A_VTH_HI:  n.rdata = q.vth_hi;
        gcca_pkg::A_VTH_LO:  n.rdata = q.vth_lo;
        gcca_pkg::A_TEMP_HI: n.rdata = q.temp[15:8];
        gcca_pkg::A_TEMP_LO: n.rdata = q.temp[7:0];
        gcca_pkg::A_TTH_HI:  n.rdata = q.tth_hi;
        default:             n.rdata = q.tth_lo;
      endcase
    end
    // Reading the high byte freezes the low byte for a low-byte read in the very next cycle only.
    if (link.rd && link.addr == gcca_pkg::A_ACR_HI) begin
      n.lo_shadow = q.charge_accumulator[7:0];
    end else if (!(link.rd && link.addr == gcca_pkg::A_ACR_LO)) begin
      n.lo_shadow = n.charge_accumulator[7:0];
    end
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q        <= '0;
      q.seq    <= gcca_pkg::SQ_SLEEP;
      q.ctrl   <= gcca_pkg::CTRL_RST;
      q.charge_accumulator    <= gcca_pkg::ACR_RST;
      q.chh    <= gcca_pkg::THR_HI_RST;
      q.chl    <= gcca_pkg::THR_LO_RST;
      q.vth_hi <= gcca_pkg::THR_HI_RST[15:8];
      q.vth_lo <= gcca_pkg::THR_LO_RST[15:8];
      q.tth_hi <= gcca_pkg::THR_HI_RST[15:8];
      q.tth_lo <= gcca_pkg::THR_LO_RST[15:8];
      q.lo_shadow <= gcca_pkg::ACR_RST[7:0];
    end else begin
      q <= n;
    end
  end

  // Outputs; the pin is driven low only in alert mode, else released.
  assign link.rdata    = q.rdata;
  assign link.rvalid   = q.rvalid;
  assign link.pin_out  = 1'b0;
  assign link.pin_oe_n = ~(q.ctrl[gcca_pkg::PIN_AL] & q.alert);
  assign analog_off    = q.ctrl[gcca_pkg::SHDN];
  assign conv_volt     = q.seq == gcca_pkg::SQ_CONV_V;
  assign conv_temp     = q.seq == gcca_pkg::SQ_CONV_T;
  assign acr_value     = q.charge_accumulator;
endmodule : gcca_device
`default_nettype wire

// *** design/gcca_host.sv ***
// Host controller: AHB-Lite registers driving the gauge register link.
`timescale 1ns/100ps
`default_nettype none
module gcca_host (
  input  wire logic        hclk,       // Clock.
  input  wire logic        hresetn,    // Asynchronous reset, active low.
  input  wire logic        hsel,       // Slave select.
  input  wire logic [31:0] haddr,      // Byte address.
  input  wire logic [1:0]  htrans,     // Transfer type.
  input  wire logic        hwrite,     // Write when high.
  input  wire logic [2:0]  hsize,      // Transfer size, word only.
  input  wire logic [31:0] hwdata,     // Write data.
  input  wire logic        hready,     // Bus ready.
  output logic             hreadyout,  // Slave ready.
  output logic             hresp,      // Response, always OKAY.
  output logic [31:0]      hrdata,     // Read data.
  gcca_if.host             link        // Link to the device.
);
  typedef struct packed {
    gcca_pkg::gcca_hst_t st;
    logic        ap_wr;
    logic [3:0]  ap_addr;
    logic [31:0] hrdata;
    logic        pair;
    logic [15:0] result;
    logic [7:0]  ctrl_shadow;
    logic        refused;
    logic        wr;
    logic        rd;
    logic        ara;
    logic [3:0]  addr;
    logic [7:0]  wdata;
  } gcca_hst_st_t;

  gcca_hst_st_t q;
  gcca_hst_st_t n;
  logic         bad;

  // Next-state logic of the bus slave and the link sequencer.
  always_comb begin
    n       = q;
    n.wr    = 1'b0;
    n.rd    = 1'b0;
    n.ara   = 1'b0;
    n.ap_wr = 1'b0;
    bad     = 1'b0;
    // Address phase: latch a write, or fetch read data at once.
    if (hsel && htrans[1] && hready) begin
      n.ap_wr   = hwrite;
      n.ap_addr = haddr[3:0];
      if (!hwrite) begin
        case (haddr[3:0])
          gcca_pkg::H_STAT:   n.hrdata = {29'h0, q.refused,
                                          ~link.pin_lvl, q.st != gcca_pkg::HS_IDLE};
          gcca_pkg::H_RESULT: n.hrdata = {16'h0, q.result};
          default:            n.hrdata = 32'h0;
        endcase
      end
    end
    // Data phase of a command write.
    if (q.ap_wr && q.ap_addr == gcca_pkg::H_CMD) begin
      bad = (q.st != gcca_pkg::HS_IDLE) ||
            (!hwdata[gcca_pkg::C_ARA] && !hwdata[gcca_pkg::C_READ] &&
             !hwdata[gcca_pkg::C_PAIR] &&
             ((hwdata[11:8] == gcca_pkg::A_CTRL &&
               hwdata[gcca_pkg::PIN_AL:gcca_pkg::PIN_CC] ==
               gcca_pkg::PIN_BOTH) ||
              ((hwdata[11:8] == gcca_pkg::A_ACR_HI ||
                hwdata[11:8] == gcca_pkg::A_ACR_LO) &&
               !q.ctrl_shadow[gcca_pkg::SHDN])));
      n.refused = bad;
      if (!bad) begin
        n.addr  = hwdata[11:8];
        n.wdata = hwdata[7:0];
        if (hwdata[gcca_pkg::C_ARA]) begin
          n.ara = 1'b1;
        end else if (hwdata[gcca_pkg::C_READ] || hwdata[gcca_pkg::C_PAIR]) begin
          n.rd   = 1'b1;
          n.pair = hwdata[gcca_pkg::C_PAIR];
          n.st   = gcca_pkg::HS_WAIT1;
        end else begin
          n.wr = 1'b1;
          if (hwdata[11:8] == gcca_pkg::A_CTRL) begin
            n.ctrl_shadow = hwdata[7:0];
          end
        end
      end
    end
    // Link sequencer; a pair read fetches the second byte two cycles after the first.
    case (q.st)
      gcca_pkg::HS_IDLE: begin
        n.pair = n.pair;
      end
      gcca_pkg::HS_WAIT1: begin
        if (link.rvalid) begin
          if (q.pair) begin
            n.result[15:8] = link.rdata;
            n.rd   = 1'b1;
            n.addr = q.addr + 4'h1;
            n.st   = gcca_pkg::HS_WAIT2;
          end else begin
            n.result = {8'h00, link.rdata};
            n.st     = gcca_pkg::HS_IDLE;
          end
        end
      end
      gcca_pkg::HS_WAIT2: begin
        if (link.rvalid) begin
          n.result[7:0] = link.rdata;
          n.st          = gcca_pkg::HS_IDLE;
        end
      end
      default: begin
        n.st = gcca_pkg::HS_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q             <= '0;
      q.st          <= gcca_pkg::HS_IDLE;
      q.ctrl_shadow <= gcca_pkg::CTRL_RST;
    end else begin
      q <= n;
    end
  end

  // Outputs; the slave never stalls and never errs.
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = q.hrdata;
  assign link.wr    = q.wr;
  assign link.rd    = q.rd;
  assign link.ara   = q.ara;
  assign link.addr  = q.addr;
  assign link.wdata = q.wdata;
endmodule : gcca_host
`default_nettype wire

// *** dv/gcca_monitor.sv ***
// Link checker for the gauge device and its host controller.
`timescale 1ns/100ps
`default_nettype none
module gcca_monitor #(
  parameter logic CHIP_ID = 1'b0  // Arbitrary value.
) (
  input wire logic       hclk,     // Clock.
  input wire logic       hresetn,  // Reset, active low.
  input wire logic       wr,       // Write strobe.
  input wire logic       rd,       // Read strobe.
  input wire logic [3:0] addr,     // Register address.
  input wire logic [7:0] wdata,    // Write data.
  input wire logic [7:0] rdata,    // Read data.
  input wire logic       rvalid,   // Read data valid.
  input wire logic       ara,      // Alert response done.
  input wire logic       pin_out,  // Pin drive value.
  input wire logic       pin_oe_n  // Pin enable, active low.
);
  logic [7:0] sh_q;  // Last control byte written.
  logic       wr_q;  // Control written since reset.
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Shadows the control byte from link writes.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sh_q <= gcca_pkg::CTRL_RST;
      wr_q <= 1'b0;
    end else if (wr && addr == gcca_pkg::A_CTRL) begin
      sh_q <= wdata;
      wr_q <= 1'b1;
    end
  end
  a_read_answer: assert property (rd |=> rvalid)
    else $error("read got no answer");
  a_valid_cause: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  a_alert_low: assert property (!pin_oe_n |-> !pin_out)
    else $error("alert not driven low");
  a_pin_off: assert property (!sh_q[2] && !$past(sh_q[2])
    && !$past(sh_q[2], 2) |-> pin_oe_n)
    else $error("pin driven outside alert mode");
  a_ara_release: assert property (ara |-> ##[1:2] pin_oe_n)
    else $error("alert not released");
  a_ctrl_reset: assert property (rd && addr == gcca_pkg::A_CTRL
    && !wr_q |=> rdata == gcca_pkg::CTRL_RST)
    else $error("control reset value wrong");
  a_ctrl_keep: assert property (rd && addr == gcca_pkg::A_CTRL
    |=> rdata[5:0] == sh_q[5:0])
    else $error("control bits lost");
  a_status_fixed: assert property (rd && addr == gcca_pkg::A_STATUS
    |=> rdata[7] == CHIP_ID && rdata[6] == 1'b0 && rdata[0] == 1'b0)
    else $error("status fixed bits wrong");
endmodule : gcca_monitor
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the gauge device and its host controller.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        hclk, hresetn, hwrite, hready, hresp, chg_up, chg_dn;
  logic        analog_off, conv_volt, conv_temp;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [15:0] adc_volt, adc_temp, acr_value, e;
  int          bad_count, tests_run;
  logic [47:0] rows [12] = '{{32'h1100, 16'h003c}, {32'h2200, 16'h7fff},
    {32'h1400, 16'h00ff}, {32'h1600, 16'h0000}, {32'h1a00, 16'h00ff},
    {32'h1f00, 16'h0000}, {32'h0101, 16'h0000}, {32'h0212, 16'h0000},
    {32'h0334, 16'h0000}, {32'h2200, 16'h1234}, {32'h1000, 16'h0000},
    {32'h1100, 16'h0001}};
  gcca_if lnk ();
  gcca_host gcca_host_i (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp,
    .hrdata, .link(lnk));
  gcca_device #(.CONV_CYC(40), .SCAN_CYC(60)) gcca_device_i (.hclk,
    .hresetn, .link(lnk), .chg_up, .chg_dn, .adc_volt, .adc_temp,
    .analog_off, .conv_volt, .conv_temp, .acr_value);
  gcca_monitor gcca_monitor_i (.hclk, .hresetn, .wr(lnk.wr), .rd(lnk.rd),
    .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
    .rvalid(lnk.rvalid), .ara(lnk.ara), .pin_out(lnk.pin_out),
    .pin_oe_n(lnk.pin_oe_n));
  // Makes the 250 MHz clock.
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Prints the verdict and ends the run.
  task automatic results();
    if (bad_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results
  // Compares one value and counts it.
  task automatic chk(string s, logic [31:0] x, logic [31:0] g);
    tests_run++;
    if (x !== g) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", s, x, g);
    end
  endtask : chk
  // Ends the run when a wait used up its bound.
  task automatic lim(int n, int m);
    if (n >= m) begin
      bad_count++;
      results();
    end
  endtask : lim
  // One AHB single word transfer; read data lands in r.
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
    int n;
    n = 0;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 99);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1 && ++n < 99);
    lim(n, 99);
    r = hrdata;
  endtask : xfer
  // Issues a link command, waits until idle, reads the result word.
  task automatic cmd(logic [31:0] c);
    int n;
    n = 0;
    xfer(1'b1, 32'(gcca_pkg::H_CMD), c);
    do xfer(1'b0, 32'(gcca_pkg::H_STAT), 0); while (r[0] !== 0 && ++n < 30);
    lim(n, 30);
    xfer(1'b0, 32'(gcca_pkg::H_RESULT), 0);
  endtask : cmd
  // Feeds n charge sub-steps in one direction.
  task automatic pulse(int n, logic dn);
    chg_up <= !dn;
    chg_dn <= dn;
    repeat (n) @(posedge hclk);
    chg_up <= 1'b0;
    chg_dn <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask : pulse
  // Waits for a given pair of conversion flags.
  task automatic wcv(logic [1:0] v);
    int n;
    for (n = 0; n < 400 && {conv_volt, conv_temp} !== v; n++)
      @(posedge hclk);
    lim(n, 400);
  endtask : wcv
  // Main sequence: table rows first, then the hand-written cases.
  initial begin
    hresetn = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    chg_up = 1'b0;
    chg_dn = 1'b0;
    adc_volt = 16'h0;
    adc_temp = 16'h0;
    lnk.pin_ext = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (rows[i]) begin
      cmd(rows[i][47:16]);
      if (rows[i][29:28] != 2'b00)
        chk("row", {16'h0, rows[i][15:0]}, r);
    end
    e = 16'h1234;
    for (int k = 0; k < 3; k++) begin
      cmd(32'h0104 | (k << 3));
      pulse((8 << k) - 1, 1'b0);
      chk("residue", e, acr_value);
      pulse(1, 1'b0);
      e++;
      chk("prescale", e, acr_value);
    end
    cmd(32'h0104);
    pulse(8, 1'b1);
    e--;
    chk("down", e, acr_value);
    pulse(5, 1'b0);
    cmd(32'h0105);
    pulse(20, 1'b0);
    chk("off", e, acr_value);
    cmd(32'h0104);
    pulse(7, 1'b0);
    chk("lost", e, acr_value);
    cmd(32'h0102);
    lnk.pin_ext <= 1'b1;
    repeat (4) @(posedge hclk);
    lnk.pin_ext <= 1'b0;
    chk("full", 16'hffff, acr_value);
    pulse(8, 1'b0);
    chk("sat", 16'hffff, acr_value);
    cmd(32'h1000);
    chk("ovf", 1, r[5]);
    lnk.pin_ext <= 1'b1;
    cmd(32'h0104);
    cmd(32'h0400);
    xfer(1'b0, 32'(gcca_pkg::H_STAT), 0);
    chk("alert", 1, r[1]);
    cmd(32'h4000);
    xfer(1'b0, 32'(gcca_pkg::H_STAT), 0);
    chk("release", 0, r[1]);
    cmd(32'h0106);
    xfer(1'b0, 32'(gcca_pkg::H_STAT), 0);
    chk("both_refused", 1, r[2]);
    cmd(32'h0200);
    xfer(1'b0, 32'(gcca_pkg::H_STAT), 0);
    chk("acr_guard", 1, r[2]);
    adc_volt <= 16'h1234;
    adc_temp <= 16'h5600;
    cmd(32'h0a11);
    for (int k = 0; k < 2; k++) begin
      cmd(k ? 32'h0144 : 32'h0184);
      wcv(k ? 2'b01 : 2'b10);
      wcv(2'b00);
      cmd(32'h1100);
      chk("mode", 0, r[7:6]);
      cmd(k ? 32'h2c00 : 32'h2800);
      chk("result", k ? 32'h5600 : 32'h1234, r);
    end
    cmd(32'h1000);
    chk("flags", 2'b01, {r[4], r[1]});
    adc_volt <= 16'h2200;
    cmd(32'h01c4);
    wcv(2'b10);
    wcv(2'b01);
    cmd(32'h2800);
    chk("vfirst", 32'h2200, r);
    wcv(2'b00);
    wcv(2'b10);
    cmd(32'h0104);
    chk("finish", 1, conv_volt);
    wcv(2'b00);
    repeat (150) @(posedge hclk);
    chk("asleep", 0, {conv_volt, conv_temp});
    results();
  end
endmodule : tb
`default_nettype wire
